// [core/hsps_map.svh]
/*
 * Constants of the hot-swap power sequencer: register offsets, reset values,
 * delay tables in microseconds and timing counts.
 * Assumes the core clock runs at 250 MHz and is included by bare name.
 */
`ifndef HSPS_MAP_SVH
`define HSPS_MAP_SVH

// ----------------------------------------------------------------
// clock and timebase
// ----------------------------------------------------------------
`define HSPS_CLK_NS          4
`define HSPS_TICK_NS         1000
`define HSPS_TICK_CYCLES     (`HSPS_TICK_NS / `HSPS_CLK_NS)
`define HSPS_GLITCH_NS       100
`define HSPS_GLITCH_CYCLES   (`HSPS_GLITCH_NS / `HSPS_CLK_NS + 1)

// ----------------------------------------------------------------
// delay tables, microseconds
// ----------------------------------------------------------------
`define HSPS_SD0_US          23'd500
`define HSPS_SD1_US          23'd5000
`define HSPS_SD2_US          23'd80000
`define HSPS_SD3_US          23'd160000
`define HSPS_PGD0_US         23'd5000
`define HSPS_PGD1_US         23'd20000
`define HSPS_PGD2_US         23'd80000
`define HSPS_PGD3_US         23'd160000
`define HSPS_UVF1_US         23'd5000
`define HSPS_UVF2_US         23'd80000
`define HSPS_UVF3_US         23'd160000
`define HSPS_CBD0_US         23'd5
`define HSPS_CBD1_US         23'd50
`define HSPS_CBD2_US         23'd150
`define HSPS_CBD3_US         23'd400
`define HSPS_CYC1_US         23'd2500000
`define HSPS_CYC2_US         23'd5000000
`define HSPS_HOLDOFF_US      100000

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define HSPS_OFS_CFG         8'h00
`define HSPS_OFS_TRIP        8'h01
`define HSPS_OFS_CMD         8'h02
`define HSPS_OFS_STATUS      8'h03
`define HSPS_RST_CFG         8'h02
`define HSPS_RST_TRIP        8'h19
`define HSPS_RST_CMD         8'h01
`define HSPS_CMD_PWR_BIT     0
`define HSPS_CMD_CLR_BIT     1
`define HSPS_I2C_ADDR        7'h48

`endif

// [core/hsps_pkg.sv]
/*
 * Types of the hot-swap power sequencer.
 * Assumes hsps_map.svh holds the numeric constants.
 */
`default_nettype none
package hsps_pkg;

	typedef enum logic [4:0] {
		ST_IDLE  = 5'h01,
		ST_START = 5'h02,
		ST_RAMP  = 5'h04,
		ST_ON    = 5'h08,
		ST_FAULT = 5'h10
	} hsps_state_type;

	typedef struct packed {
		logic [1:0] retry;
		logic [1:0] filt;
		logic [1:0] pgd;
		logic [1:0] startup;
	} hsps_cfg_type;

	typedef struct packed {
		logic [3:0] hyst;
		logic [1:0] fast;
		logic [1:0] cbd;
	} hsps_trip_type;

	typedef struct packed {
		logic creg;
		logic fs_n;
		logic fast;
		logic cs;
		logic gate_sat;
		logic drain_lo;
		logic en;
		logic ov;
		logic uv;
	} hsps_sense_type;

endpackage

`default_nettype wire

// [core/hsps_sequencer.sv]
/*
 * Digital sequencing, fault logic and serial configuration target of a
 * hot-swap controller.
 * Assumes analog comparators drive the sense inputs asynchronously and
 * an external open-drain buffer resolves the serial data pin.
 */
// Decided for this implementation: the placing of the registers and the strobed register port.
// What this block does
// - startup delay before gate, default 80 ms
// - power-up only with supply inside limits
// - unfiltered supply fault drops gate, power-good
// - filter ignores short faults, latches long ones
// - supply filter off by default
// - undervolt hysteresis setting, default one step
// - gate on only while master enable high
// - power-good needs drain low and gate saturated
// - gate saturation result latched once seen
// - drain ignored during current regulation
// - power-good delay, default 5 ms
// - forced shutdown honoured after hold-off
// - breaker trips after filtered overcurrent
// - fast trip threshold selectable, no filter
// - fast trip drops gate within 200 ns
// - retry cycle 2.5 s, 5 s, or off
// - one bit per clock, data stable high
// - serial glitches to 100 ns rejected
// - fault latches off or retries
`timescale 1ns/1ps
`default_nettype none
`include "hsps_map.svh"

module hsps_sequencer
	import hsps_pkg::*;
#(
	parameter int          TICK_CYCLES = `HSPS_TICK_CYCLES,
	parameter int          HOLDOFF_US  = `HSPS_HOLDOFF_US,
	parameter logic [6:0]  DEV_ADDR    = `HSPS_I2C_ADDR
)
(
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	input  wire logic       undervolt_in,
	input  wire logic       overvolt_in,
	input  wire logic       master_enable_in,
	input  wire logic       drain_low_in,
	input  wire logic       gate_sat_in,
	input  wire logic       current_sense_in,
	input  wire logic       fast_trip_in,
	input  wire logic       forced_shutdown_n_in,
	input  wire logic       cur_reg_active_in,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	input  wire logic [7:0] reg_addr_in,
	input  wire logic [7:0] reg_wdata_in,
	input  wire logic       reg_wr_in,
	input  wire logic       reg_rd_in,
	output logic      [7:0] reg_rdata_out,
	output logic            gate_drive_out,
	output logic            power_good_n_out,
	output logic      [3:0] uv_hyst_out,
	output logic      [1:0] fast_trip_threshold_out,
	output logic            sda_out,
	output logic            sda_oe_n_out
);

	// ----------------------------------------------------------------
	// delay tables
	// ----------------------------------------------------------------
	function automatic logic [22:0] startup_delay(input logic [1:0] s);
		case (s)
			2'd0:    return `HSPS_SD0_US;
			2'd1:    return `HSPS_SD1_US;
			2'd2:    return `HSPS_SD2_US;
			default: return `HSPS_SD3_US;
		endcase
	endfunction

	function automatic logic [22:0] power_good_delay(input logic [1:0] s);
		case (s)
			2'd0:    return `HSPS_PGD0_US;
			2'd1:    return `HSPS_PGD1_US;
			2'd2:    return `HSPS_PGD2_US;
			default: return `HSPS_PGD3_US;
		endcase
	endfunction

	function automatic logic [22:0] supply_filter_delay(input logic [1:0] s);
		case (s)
			2'd1:    return `HSPS_UVF1_US;
			2'd2:    return `HSPS_UVF2_US;
			default: return `HSPS_UVF3_US;
		endcase
	endfunction

	function automatic logic [22:0] breaker_filter_delay(input logic [1:0] s);
		case (s)
			2'd0:    return `HSPS_CBD0_US;
			2'd1:    return `HSPS_CBD1_US;
			2'd2:    return `HSPS_CBD2_US;
			default: return `HSPS_CBD3_US;
		endcase
	endfunction

	// retry code 3 is treated like off
	function automatic logic [22:0] retry_delay(input logic [1:0] s);
		return (s == 2'd1) ? `HSPS_CYC1_US : `HSPS_CYC2_US;
	endfunction

	// ----------------------------------------------------------------
	// input synchronisers and serial glitch filter
	// ----------------------------------------------------------------
	localparam int GLITCH = `HSPS_GLITCH_CYCLES;

	logic [10:0]    sync1_q;
	logic [10:0]    sync2_q;
	hsps_sense_type sen;
	logic [1:0]     flt_q;
	logic [1:0]     flt_prev_q;
	logic [4:0]     gcnt_q [2];

	assign sen = hsps_sense_type'(sync2_q[10:2]);

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			sync1_q <= 11'h207;
			sync2_q <= 11'h207;
		end
		else
		begin
			sync1_q <= {cur_reg_active_in, forced_shutdown_n_in, fast_trip_in, current_sense_in,
				gate_sat_in, drain_low_in, master_enable_in, overvolt_in, undervolt_in, sda_in, scl_in};
			sync2_q <= sync1_q;
		end
	end

	// a new serial level must hold past the glitch window before it counts
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			flt_q      <= 2'h3;
			flt_prev_q <= 2'h3;
			gcnt_q[0]  <= 5'h00;
			gcnt_q[1]  <= 5'h00;
		end
		else
		begin
			flt_prev_q <= flt_q;
			for (int i = 0; i < 2; i++)
			begin
				if (sync2_q[i] == flt_q[i])
					gcnt_q[i] <= 5'h00;
				else if (gcnt_q[i] == 5'(GLITCH - 1))
				begin
					flt_q[i]  <= sync2_q[i];
					gcnt_q[i] <= 5'h00;
				end
				else
					gcnt_q[i] <= gcnt_q[i] + 5'h01;
			end
		end
	end

	wire scl_rise = flt_q[0] & ~flt_prev_q[0];
	wire scl_fall = ~flt_q[0] & flt_prev_q[0];
	wire start_c  = flt_q[0] & flt_prev_q[0] & ~flt_q[1] & flt_prev_q[1];
	wire stop_c   = flt_q[0] & flt_prev_q[0] & flt_q[1] & ~flt_prev_q[1];

	// ----------------------------------------------------------------
	// configuration storage
	// ----------------------------------------------------------------
	hsps_cfg_type  cfg_q;
	hsps_trip_type trip_q;
	logic          pwr_en_q;
	logic          clr_q;
	logic [3:0]    cause_q;
	logic          i2c_we;
	logic [7:0]    i2c_ptr_q;
	logic [7:0]    i2c_shift_q;
	logic [7:0]    rd_mux_i2c;
	logic [7:0]    rd_mux_bus;
	hsps_state_type st_q;
	hsps_state_type st_d;
	logic          sat_q;

	// the parallel port wins when both sides write in one cycle
	wire       we    = reg_wr_in | i2c_we;
	wire [7:0] waddr = reg_wr_in ? reg_addr_in : i2c_ptr_q;
	wire [7:0] wdata = reg_wr_in ? reg_wdata_in : i2c_shift_q;
	wire [7:0] status_v = {cause_q, sat_q, st_q == ST_FAULT, st_q == ST_ON, gate_drive_out};

	function automatic logic [7:0] reg_read(input logic [7:0] a, input logic [7:0] cfg,
		input logic [7:0] trp, input logic pwr, input logic [7:0] sts);
		case (a)
			`HSPS_OFS_CFG:    return cfg;
			`HSPS_OFS_TRIP:   return trp;
			`HSPS_OFS_CMD:    return {7'h00, pwr};
			`HSPS_OFS_STATUS: return sts;
			default:          return 8'h00;
		endcase
	endfunction

	assign rd_mux_bus = reg_read(reg_addr_in, cfg_q, trip_q, pwr_en_q, status_v);
	assign rd_mux_i2c = reg_read(i2c_ptr_q, cfg_q, trip_q, pwr_en_q, status_v);

	// writes land at once, so the host's write-cycle wait is always met
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			cfg_q    <= `HSPS_RST_CFG;
			trip_q   <= `HSPS_RST_TRIP;
			pwr_en_q <= 1'b1;
			clr_q    <= 1'b0;
		end
		else
		begin
			clr_q <= we & (waddr == `HSPS_OFS_CMD) & wdata[`HSPS_CMD_CLR_BIT];
			if (we && waddr == `HSPS_OFS_CFG)
				cfg_q <= hsps_cfg_type'(wdata);
			if (we && waddr == `HSPS_OFS_TRIP)
				trip_q <= hsps_trip_type'(wdata);
			if (we && waddr == `HSPS_OFS_CMD)
				pwr_en_q <= wdata[`HSPS_CMD_PWR_BIT];
		end
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			reg_rdata_out           <= 8'h00;
			uv_hyst_out             <= 4'h1;
			fast_trip_threshold_out <= 2'h2;
		end
		else
		begin
			reg_rdata_out           <= reg_rd_in ? rd_mux_bus : 8'h00;
			uv_hyst_out             <= trip_q.hyst;
			fast_trip_threshold_out <= trip_q.fast;
		end
	end

	// ----------------------------------------------------------------
	// serial configuration target
	// ----------------------------------------------------------------
	localparam logic [1:0] PH_ADDR = 2'd0;
	localparam logic [1:0] PH_PTR  = 2'd1;
	localparam logic [1:0] PH_WR   = 2'd2;
	localparam logic [1:0] PH_RD   = 2'd3;

	logic       i2c_act_q;
	logic [3:0] bit_q;
	logic [1:0] phase_q;
	logic [7:0] tx_q;
	logic       mnack_q;
	logic       sda_lvl_q;

	assign i2c_we = i2c_act_q & scl_fall & (bit_q == 4'd8) & (phase_q == PH_WR);

	// everything moves on filtered edges only, so any clock rate down to static works
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			i2c_act_q    <= 1'b0;
			bit_q        <= 4'd0;
			phase_q      <= PH_ADDR;
			i2c_shift_q  <= 8'h00;
			i2c_ptr_q    <= 8'h00;
			tx_q         <= 8'h00;
			mnack_q      <= 1'b0;
			sda_oe_n_out <= 1'b1;
		end
		else if (start_c)
		begin
			i2c_act_q    <= 1'b1;
			bit_q        <= 4'd0;
			phase_q      <= PH_ADDR;
			sda_oe_n_out <= 1'b1;
		end
		else if (stop_c)
		begin
			i2c_act_q    <= 1'b0;
			sda_oe_n_out <= 1'b1;
		end
		else if (i2c_act_q && scl_rise)
		begin
			if (bit_q < 4'd8)
				i2c_shift_q <= {i2c_shift_q[6:0], flt_q[1]};
			else
				mnack_q <= flt_q[1];
			bit_q <= bit_q + 4'd1;
		end
		else if (i2c_act_q && scl_fall)
		begin
			if (bit_q == 4'd8)
			begin
				sda_oe_n_out <= 1'b0;
				case (phase_q)
					PH_ADDR:
					begin
						if (i2c_shift_q[7:1] != DEV_ADDR)
						begin
							i2c_act_q    <= 1'b0;
							sda_oe_n_out <= 1'b1;
						end
						else
							phase_q <= i2c_shift_q[0] ? PH_RD : PH_PTR;
					end
					PH_PTR:
					begin
						i2c_ptr_q <= i2c_shift_q;
						phase_q   <= PH_WR;
					end
					PH_WR:
						i2c_ptr_q <= i2c_ptr_q + 8'h01;
					default:
						sda_oe_n_out <= 1'b1;
				endcase
			end
			else if (bit_q == 4'd9)
			begin
				bit_q <= 4'd0;
				if (phase_q == PH_RD && !mnack_q)
				begin
					tx_q         <= {rd_mux_i2c[6:0], 1'b0};
					sda_oe_n_out <= rd_mux_i2c[7];
					i2c_ptr_q    <= i2c_ptr_q + 8'h01;
				end
				else
				begin
					sda_oe_n_out <= 1'b1;
					if (phase_q == PH_RD)
						i2c_act_q <= 1'b0;
				end
			end
			else if (phase_q == PH_RD)
			begin
				sda_oe_n_out <= tx_q[7];
				tx_q         <= {tx_q[6:0], 1'b0};
			end
		end
	end

	assign sda_out = sda_lvl_q;

	// ----------------------------------------------------------------
	// timebase and delay counters
	// ----------------------------------------------------------------
	logic [15:0] tick_cnt_q;
	logic [22:0] tmr_q;
	logic [22:0] uvf_q;
	logic [22:0] cb_q;
	logic [22:0] hold_q;

	wire tick      = (tick_cnt_q == 16'(TICK_CYCLES - 1));
	wire supply_ok = sen.uv & ~sen.ov;
	wire run_ok    = sen.en & pwr_en_q;
	wire powered   = (st_q == ST_RAMP) | (st_q == ST_ON);
	wire pg_cond   = sat_q & (sen.drain_lo | sen.creg);
	wire ft_trip   = sen.fast & (trip_q.fast != 2'd0);
	wire cb_trip   = cb_q >= breaker_filter_delay(trip_q.cbd);
	wire uv_fault  = ~supply_ok & ((cfg_q.filt == 2'd0) | (uvf_q >= supply_filter_delay(cfg_q.filt)));
	wire fs_fault  = (hold_q >= 23'(HOLDOFF_US)) & ~sen.fs_n;
	wire any_fault = ft_trip | cb_trip | uv_fault | fs_fault | ((st_q == ST_ON) & ~pg_cond);
	wire tmr_clr   = (st_d != st_q) | ((st_q == ST_RAMP) & ~pg_cond);

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			tick_cnt_q <= 16'h0000;
			tmr_q      <= 23'h000000;
			uvf_q      <= 23'h000000;
			cb_q       <= 23'h000000;
			hold_q     <= 23'h000000;
		end
		else
		begin
			tick_cnt_q <= tick ? 16'h0000 : tick_cnt_q + 16'h0001;
			if (tmr_clr)
				tmr_q <= 23'h000000;
			else if (tick && tmr_q != 23'h7fffff)
				tmr_q <= tmr_q + 23'h000001;
			if (supply_ok || !powered)
				uvf_q <= 23'h000000;
			else if (tick && uvf_q != 23'h7fffff)
				uvf_q <= uvf_q + 23'h000001;
			if (!sen.cs || !powered)
				cb_q <= 23'h000000;
			else if (tick && cb_q != 23'h7fffff)
				cb_q <= cb_q + 23'h000001;
			if (!powered)
				hold_q <= 23'h000000;
			else if (tick && hold_q != 23'(HOLDOFF_US))
				hold_q <= hold_q + 23'h000001;
		end
	end

	// ----------------------------------------------------------------
	// power sequence
	// ----------------------------------------------------------------
	always_comb
	begin
		st_d = st_q;
		case (st_q)
			ST_IDLE:
				if (run_ok && supply_ok)
					st_d = ST_START;
			ST_START:
				if (!run_ok || !supply_ok)
					st_d = ST_IDLE;
				else if (tmr_q >= startup_delay(cfg_q.startup))
					st_d = ST_RAMP;
			ST_RAMP, ST_ON:
				if (!run_ok)
					st_d = ST_IDLE;
				else if (any_fault)
					st_d = ST_FAULT;
				else if (st_q == ST_RAMP && pg_cond && tmr_q >= power_good_delay(cfg_q.pgd))
					st_d = ST_ON;
			ST_FAULT:
				if (clr_q)
					st_d = ST_IDLE;
				else if (cfg_q.retry != 2'd0 && cfg_q.retry != 2'd3
					&& tmr_q >= retry_delay(cfg_q.retry))
					st_d = ST_IDLE;
			default:
				st_d = ST_IDLE;
		endcase
	end

	// outputs follow the next state, so a fault drops them on the same edge
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			st_q             <= ST_IDLE;
			gate_drive_out   <= 1'b0;
			power_good_n_out <= 1'b1;
			sat_q            <= 1'b0;
			cause_q          <= 4'h0;
		end
		else
		begin
			st_q             <= st_d;
			gate_drive_out   <= (st_d == ST_RAMP) | (st_d == ST_ON);
			power_good_n_out <= ~(st_d == ST_ON);
			if (!powered)
				sat_q <= 1'b0;
			else if (sen.gate_sat)
				sat_q <= 1'b1;
			if (st_d == ST_FAULT && st_q != ST_FAULT)
				cause_q <= {fs_fault, ft_trip, cb_trip, uv_fault};
		end
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			sda_lvl_q <= 1'b0;
		else
			sda_lvl_q <= 1'b0;
	end

endmodule // hsps_sequencer

`default_nettype wire

// [tb/hsps_chk.sv]
/* port checker of the sequencer.
 assumes bind onto hsps_sequencer, one clock domain */
`timescale 1ns/1ps
`default_nettype none
module hsps_chk
#(
	parameter int TICK_CYCLES = 250,
	parameter int HOLDOFF_US  = 100000
)
(
	input wire logic       clk_in,
	input wire logic       rst_in,
	input wire logic       undervolt_in,
	input wire logic       overvolt_in,
	input wire logic       master_enable_in,
	input wire logic       drain_low_in,
	input wire logic       gate_sat_in,
	input wire logic       fast_trip_in,
	input wire logic       forced_shutdown_n_in,
	input wire logic       cur_reg_active_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic       reg_rd_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic       gate_drive_out,
	input wire logic       power_good_n_out,
	input wire logic [1:0] fast_trip_threshold_out,
	input wire logic       sda_out,
	input wire logic       sda_oe_n_out
);
	// margin covers input sync and the tick phase
	localparam int LIM = HOLDOFF_US * TICK_CYCLES + 16;
	int unsigned on_q;
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	always_ff @(posedge clk_in or posedge rst_in)
		if (rst_in || !gate_drive_out)
			on_q <= 0;
		else if (on_q < LIM)
			on_q <= on_q + 1;
	gate_enable_a: assert property (!master_enable_in [*5] |-> !gate_drive_out)
		else $error("gate on without enable");
	supply_fault_a: assert property ((!undervolt_in || overvolt_in) [*5] |->
		!gate_drive_out && power_good_n_out) else $error("supply fault ignored");
	fast_trip_a: assert property ($rose(fast_trip_in) && fast_trip_threshold_out != 2'h0
		|-> ##[1:50] !gate_drive_out) else $error("fast trip too slow");
	pg_gate_a: assert property (!power_good_n_out |-> gate_drive_out)
		else $error("power good without gate");
	pg_drain_a: assert property ((!drain_low_in && !cur_reg_active_in) [*5] |-> power_good_n_out)
		else $error("power good with drain high");
	sat_latch_a: assert property (!power_good_n_out && $fell(gate_sat_in) |=> !power_good_n_out [*4])
		else $error("saturation not latched");
	rdata_idle_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
		else $error("read data outside slot");
	unmapped_rd_a: assert property ($past(reg_rd_in) && $past(reg_addr_in) > 8'h03 |->
		reg_rdata_out == 8'h00) else $error("unmapped read not zero");
	holdoff_fs_a: assert property ($fell(forced_shutdown_n_in) && on_q >= LIM |->
		##[1:6] !gate_drive_out) else $error("forced shutdown ignored");
	sda_level_a: assert property (!sda_out)
		else $error("sda driven high");
	cover property ($fell(power_good_n_out));
	cover property ($fell(gate_drive_out) && fast_trip_in);
	cover property ($fell(sda_oe_n_out));
endmodule // hsps_chk
bind hsps_sequencer hsps_chk #(.TICK_CYCLES(TICK_CYCLES), .HOLDOFF_US(HOLDOFF_US)) u_chk (
	.clk_in, .rst_in, .undervolt_in, .overvolt_in, .master_enable_in, .drain_low_in,
	.gate_sat_in, .fast_trip_in, .forced_shutdown_n_in, .cur_reg_active_in, .reg_addr_in,
	.reg_rd_in, .reg_rdata_out, .gate_drive_out, .power_good_n_out, .fast_trip_threshold_out,
	.sda_out, .sda_oe_n_out);
`default_nettype wire

// [tb/hsps_fet_model.sv]
/* power switch and secondary side seen by the sequencer.
 assumes the bench clock; drop inputs come from the bench */
`timescale 1ns/1ps
`default_nettype none
module hsps_fet_model
(
	input wire logic  clk_in,
	input wire logic  gate_drive_in,
	input wire logic  sat_drop_in,
	input wire logic  drain_bad_in,
	input wire logic  fs_low_in,
	output logic      gate_sat_out,
	output logic      drain_low_out,
	output logic      forced_shutdown_n_out
);
	int on_q;
	always_ff @(posedge clk_in)
		on_q <= gate_drive_in ? on_q + 1 : 0;
	// gate charges first, the drain collapses later
	assign gate_sat_out = (on_q > 20) && !sat_drop_in;
	assign drain_low_out = (on_q > 40) && !drain_bad_in;
	// secondary side is unpowered until well inside the hold-off
	assign forced_shutdown_n_out = (on_q > 50) && !fs_low_in;
endmodule // hsps_fet_model
`default_nettype wire

// [tb/hsps_sequencer_tb_top.sv]
/* self-checking bench of the sequencer.
 assumes a shortened tick and hold-off; serial pull-up resolved here */
`timescale 1ns/1ps
`default_nettype none
module hsps_sequencer_tb_top;
	localparam int TK = 1;
	localparam int HO = 2000;
	localparam int SD = 500 * TK;
	localparam int PG = 5000 * TK;
	logic       clk_in = 0, rst_in = 1, uv = 1, ov = 0, en = 0, cs = 0, ft = 0, cr = 0;
	logic       scl = 1, sda_d = 1, rd = 0, wr = 0, satd = 0, drb = 0, fsl = 0, ack;
	logic [7:0] ad = 8'h00, wd = 8'h00, r;
	logic [7:0] mreg [4];
	wire logic  sat, dl, fsn, g, pgn, so, soe;
	wire logic [7:0] rdat;
	wire logic [3:0] hy;
	wire logic [1:0] ftt;
	wire logic [1:0] obs = {pgn, g};
	wire logic  sda_w = sda_d & (soe | so);
	int         fail_count = 0, n_checks = 0, cyc = 0, seed = 50846, n, t0;
	hsps_sequencer #(.TICK_CYCLES(TK), .HOLDOFF_US(HO)) u_dut (.clk_in(clk_in), .rst_in(rst_in),
		.undervolt_in(uv), .overvolt_in(ov), .master_enable_in(en), .drain_low_in(dl),
		.gate_sat_in(sat), .current_sense_in(cs), .fast_trip_in(ft), .forced_shutdown_n_in(fsn),
		.cur_reg_active_in(cr), .scl_in(scl), .sda_in(sda_w), .reg_addr_in(ad), .reg_wdata_in(wd),
		.reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdat), .gate_drive_out(g),
		.power_good_n_out(pgn), .uv_hyst_out(hy), .fast_trip_threshold_out(ftt), .sda_out(so),
		.sda_oe_n_out(soe));
	hsps_fet_model u_fet (.clk_in(clk_in), .gate_drive_in(g), .sat_drop_in(satd), .drain_bad_in(drb),
		.fs_low_in(fsl), .gate_sat_out(sat), .drain_low_out(dl), .forced_shutdown_n_out(fsn));
	always #2 clk_in = ~clk_in;
	always @(posedge clk_in)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			fail_count++;
			$display("unexpected %0t run hung", $time);
			final_report;
		end
	end
	// ----
	// compares and bus cycles
	// ----
	task final_report;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("unexpected %0t got %h want %h", $time, got, exp);
		end
	endtask
	task chb(input logic got, input logic exp);
		chk({7'h00, got}, {7'h00, exp});
	endtask
	task chk_in(input int v, input int lo, input int hi);
		n_checks++;
		if (v < lo || v > hi)
		begin
			fail_count++;
			$display("unexpected %0t count %0d", $time, v);
		end
	endtask
	task tk(input int k);
		repeat (k) @(posedge clk_in);
	endtask
	task wr_r(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		ad <= a;
		wd <= d;
		wr <= 1;
		@(posedge clk_in);
		wr <= 0;
		if (a < 8'h03)
			mreg[a[1:0]] = (a == 8'h02) ? (d & 8'h01) : d;
	endtask
	task rc(input logic [7:0] a);
		@(posedge clk_in);
		ad <= a;
		rd <= 1;
		@(posedge clk_in);
		rd <= 0;
		#1 chk(rdat, (a < 8'h03) ? mreg[a[1:0]] : 8'h00);
	endtask
	task wait_o(input int i, input logic lvl);
		n = 0;
		while (obs[i] !== lvl && n < 20000)
		begin
			@(posedge clk_in);
			#1 n++;
		end
	endtask
	task src(input int k, input logic v);
		case (k)
			0: uv <= !v;
			1: ov <= v;
			2: ft <= v;
			default: cs <= v;
		endcase
	endtask
	// 32 ns pulses at the 64 ns link rate must vanish in the filter
	task ib(input logic b);
		sda_d <= b;
		tk(20);
		repeat (2)
		begin
			scl <= 1;
			tk(8);
			scl <= 0;
			tk(8);
		end
		tk(20);
		scl <= 1;
		tk(60);
		ack = sda_w;
		scl <= 0;
		tk(10);
	endtask
	task ibyte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--)
			ib(b[i]);
		ib(1'b1);
	endtask
	task sta;
		sda_d <= 0;
		tk(60);
		scl <= 0;
		tk(20);
	endtask
	task stp;
		sda_d <= 0;
		tk(30);
		scl <= 1;
		tk(60);
		sda_d <= 1;
		tk(60);
	endtask
	// ----
	// main sequence
	// ----
	initial
	begin
		mreg = '{8'h02, 8'h19, 8'h01, 8'h00};
		tk(16);
		rst_in <= 0;
		rc(8'h00);
		rc(8'h01);
		rc(8'h02);
		chk({4'h0, hy}, 8'h01);
		chk({6'h00, ftt}, 8'h02);
		r = 8'($random(seed));
		wr_r(8'h07, r);
		rc(8'h07);
		r = 8'($random(seed));
		wr_r(8'h01, r);
		rc(8'h01);
		chk({4'h0, hy}, {4'h0, r[7:4]});
		$display("test registers done");
		wr_r(8'h01, 8'h14);
		wr_r(8'h00, 8'h00);
		en <= 1;
		wait_o(0, 1);
		chk_in(n, SD - 10, SD + 20);
		t0 = cyc;
		tk(100);
		fsl <= 1;
		tk(30);
		chb(g, 1'b1);
		fsl <= 0;
		wait_o(1, 0);
		chk_in(cyc - t0, PG + 40, PG + 70);
		satd <= 1;
		tk(20);
		chb(pgn, 1'b0);
		satd <= 0;
		cr <= 1;
		tk(5);
		drb <= 1;
		tk(20);
		chb(pgn, 1'b0);
		drb <= 0;
		tk(5);
		cr <= 0;
		fsl <= 1;
		wait_o(0, 0);
		chk_in(n, 1, 8);
		chb(pgn, 1'b1);
		fsl <= 0;
		tk(600);
		chb(g, 1'b0);
		$display("test power up done");
		for (int k = 0; k < 4; k++)
		begin
			wr_r(8'h02, 8'h03);
			wait_o(0, 1);
			chk_in(n, SD - 10, SD + 20);
			src(k, 1'b1);
			wait_o(0, 0);
			chk_in(n, 1, (k == 2) ? 50 : (k == 3) ? 16 : 8);
			src(k, 1'b0);
		end
		wr_r(8'h02, 8'h03);
		wait_o(0, 1);
		cs <= 1;
		tk(3);
		cs <= 0;
		tk(20);
		chb(g, 1'b1);
		wr_r(8'h00, 8'h10);
		uv <= 0;
		tk(3);
		uv <= 1;
		tk(20);
		chb(g, 1'b1);
		wr_r(8'h01, 8'h10);
		// threshold output lags the register by a cycle
		tk(2);
		ft <= 1;
		tk(30);
		chb(g, 1'b1);
		ft <= 0;
		en <= 0;
		wait_o(0, 0);
		chk_in(n, 1, 8);
		en <= 1;
		wait_o(0, 1);
		chk_in(n, SD - 10, SD + 20);
		$display("test faults done");
		tk(60);
		sta;
		ibyte(8'h90);
		chb(ack, 1'b0);
		ibyte(8'h01);
		chb(ack, 1'b0);
		ibyte(8'h2c);
		chb(ack, 1'b0);
		stp;
		mreg[1] = 8'h2c;
		rc(8'h01);
		chk({6'h00, ftt}, 8'h03);
		sta;
		ibyte(8'h90);
		ibyte(8'h01);
		stp;
		sta;
		ibyte(8'h91);
		chb(ack, 1'b0);
		for (int i = 0; i < 8; i++)
		begin
			ib(1'b1);
			r = {r[6:0], ack};
		end
		ib(1'b1);
		stp;
		chk(r, 8'h2c);
		$display("test serial done");
		final_report;
	end
endmodule // hsps_sequencer_tb_top
`default_nettype wire
